// ===== bench/tic_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------
// Lift controller model: two relays at the end of the safety chain
// -----------------------------------------------------------------
module tic_ctrl_model #(
    parameter int unsigned OFF_MIN = 4
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic rel_a_i,
    input  wire logic rel_b_i,
    input  wire logic stuck_b_i,
    input  wire logic travel_i,
    output logic      chan_a_o,
    output logic      chan_b_o,
    output logic      travel_o
);
    logic [7:0] off_q;
    wire        both_off = !chan_a_o && !chan_b_o;
    wire        hold_off = both_off && (off_q < 8'(OFF_MIN));

    // Contacts follow coils one cycle late; once both open, both are held open for OFF_MIN cycles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            chan_a_o <= 1'b0;
            chan_b_o <= 1'b0;
            travel_o <= 1'b0;
            off_q    <= 8'(OFF_MIN);
        end else begin
            chan_a_o <= rel_a_i && !hold_off;
            chan_b_o <= (rel_b_i && !hold_off) || stuck_b_i;
            travel_o <= travel_i;
            // Saturating count of the both-open span
            off_q    <= !both_off ? 8'h00 : (off_q == 8'hff ? off_q : off_q + 8'h01);
        end
    end
endmodule : tic_ctrl_model
`default_nettype wire

// ===== bench/tic_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tic_monitor_bench;
    // -----------------------------------------------------------------
    // Shortened counts
    // -----------------------------------------------------------------
    localparam int unsigned SKEW = 8;
    localparam int unsigned LOCK = 16;
    localparam int unsigned SEQ  = 40;
    localparam int unsigned INTR = 12;

    logic              sys_clk_i, rst_i, por_i, ce_i, hw_fault_i;
    logic              rel_a, rel_b, stuck_b, trav_cmd;
    wire logic         chan_a, chan_b, travel;
    logic              gate, status, locked;
    logic [9:0]        code;
    tic_pkg::tic_flt_s warn;
    int                mismatches, total_checks;
    // Rows: {a, b, travel, gate, status}
    logic [4:0]        rows [7] = '{5'b11110, 5'b10001, 5'b11010, 5'b01001,
                                    5'b00001, 5'b11110, 5'b00001};

    tic_ctrl_model u_ctrl (.sys_clk_i(sys_clk_i), .rst_i(por_i), .rel_a_i(rel_a),
        .rel_b_i(rel_b), .stuck_b_i(stuck_b), .travel_i(trav_cmd),
        .chan_a_o(chan_a), .chan_b_o(chan_b), .travel_o(travel));

    tic_monitor #(.SKEW_CYC(SKEW), .LOCK_CYC(LOCK), .SEQ_CYC(SEQ), .INTR_CYC(INTR)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .ce_i(ce_i),
        .inhibit_channel_a_i(chan_a), .inhibit_channel_b_i(chan_b), .travel_i(travel),
        .hw_fault_i(hw_fault_i), .gate_enable_o(gate), .inhibit_status_output_o(status),
        .locked_o(locked), .fault_code_o(code), .warn_o(warn));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic chk10(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk10

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    task automatic drive(input logic a, input logic b, input logic t);
        rel_a    = a;
        rel_b    = b;
        trav_cmd = t;
    endtask : drive

    // Power-up clears the lock; relays open long enough to allow a close
    task automatic clear();
        por_i = 1'b1;
        rst_i = 1'b1;
        stuck_b = 1'b0;
        hw_fault_i = 1'b0;
        drive(1'b0, 1'b0, 1'b0);
        cyc(6);
        por_i = 1'b0;
        rst_i = 1'b0;
        cyc(2);
    endtask : clear

    // Bounded wait: the caller compares afterwards
    task automatic wait_code(input logic [9:0] exp, input int lim);
        for (int i = 0; i < lim && code !== exp; i++) cyc(1);
    endtask : wait_code

    // Two-step sequence then a timed fault with an early-miss check
    task automatic seq_case(input logic [2:0] s1, input logic [2:0] s2, input int lim,
                            input logic [9:0] exp);
        drive(s1[2], s1[1], s1[0]);
        cyc(6);
        drive(s2[2], s2[1], s2[0]);
        cyc(lim - 4);
        chk10("code early", tic_pkg::FC_NONE, code);
        wait_code(exp, 12);
        chk10("code seq", exp, code);
        clear();
    endtask : seq_case

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // -----------------------------------------------------------------
    // Clock and watchdog
    // -----------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // Whole run is under 1500 cycles; the margin covers slow lock timing
    initial begin
        repeat (6000) @(posedge sys_clk_i);
        mismatches++;
        stop_test();
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        por_i = 1'b1;
        ce_i = 1'b1;
        hw_fault_i = 1'b0;
        stuck_b = 1'b0;
        drive(1'b0, 1'b0, 1'b0);
        cyc(12);
        rst_i = 1'b0;
        por_i = 1'b0;
        cyc(3);
        chk1("gate rst", 1'b0, gate);
        chk1("status rst", 1'b1, status);
        chk1("locked rst", 1'b0, locked);
        chk10("code rst", tic_pkg::FC_NONE, code);
        // Ordinary channel combinations; mismatch rows stay under the skew limit
        foreach (rows[i]) begin
            drive(rows[i][4], rows[i][3], rows[i][2]);
            cyc(6);
            chk1("gate row", rows[i][1], gate);
            chk1("status row", rows[i][0], status);
            chk10("code row", tic_pkg::FC_NONE, code);
        end
        chk1("skew restart", 1'b0, warn.skew);
        clear();
        // Skew inside tolerance, then a relay that fails to open
        drive(1'b1, 1'b0, 1'b0);
        cyc(4);
        drive(1'b1, 1'b1, 1'b1);
        cyc(6);
        chk1("skew ok", 1'b0, warn.skew);
        chk1("gate both", 1'b1, gate);
        stuck_b = 1'b1;
        drive(1'b0, 1'b0, 1'b0);
        cyc(SKEW);
        chk1("gate single", 1'b0, gate);
        chk1("skew early", 1'b0, warn.skew);
        wait_code(tic_pkg::FC_SKEW, 12);
        chk10("code skew", tic_pkg::FC_SKEW, code);
        cyc(LOCK / 2);
        chk1("lock early", 1'b0, locked);
        wait_code(tic_pkg::FC_LOCK, LOCK + 12);
        chk10("code lock", tic_pkg::FC_LOCK, code);
        chk1("locked", 1'b1, locked);
        // Normal reset must not release the lock
        stuck_b = 1'b0;
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        drive(1'b1, 1'b1, 1'b1);
        cyc(10);
        chk1("lock held", 1'b1, locked);
        chk1("gate lock", 1'b0, gate);
        chk10("code held", tic_pkg::FC_LOCK, code);
        clear();
        chk1("lock cleared", 1'b0, locked);
        drive(1'b1, 1'b1, 1'b1);
        cyc(6);
        chk1("gate restart", 1'b1, gate);
        // Internal defect locks the stage off
        hw_fault_i = 1'b1;
        cyc(10);
        chk1("hw locked", 1'b1, locked);
        chk1("hw gate", 1'b0, gate);
        clear();
        // Sequencing faults: {a, b, travel} before and after
        seq_case(3'b000, 3'b001, SEQ, tic_pkg::FC_REMAIN);
        seq_case(3'b000, 3'b110, SEQ, tic_pkg::FC_NOTRV);
        seq_case(3'b111, 3'b110, SEQ, tic_pkg::FC_MISS);
        seq_case(3'b111, 3'b001, INTR, tic_pkg::FC_INTR);
        // Clock enable low freezes the path
        ce_i = 1'b0;
        drive(1'b1, 1'b1, 1'b1);
        cyc(8);
        chk1("gate frozen", 1'b0, gate);
        ce_i = 1'b1;
        cyc(6);
        chk1("gate thawed", 1'b1, gate);
        stop_test();
    end
endmodule : tic_monitor_bench
`default_nettype wire

// ===== hdl/tic_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tic_monitor #(
    parameter int unsigned SKEW_CYC = tic_pkg::SKEW_CYC,
    parameter int unsigned LOCK_CYC = tic_pkg::LOCK_CYC,
    parameter int unsigned SEQ_CYC  = tic_pkg::SEQ_CYC,
    parameter int unsigned INTR_CYC = tic_pkg::INTR_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       por_i,
    input  wire logic       ce_i,
    input  wire logic       inhibit_channel_a_i,
    input  wire logic       inhibit_channel_b_i,
    input  wire logic       travel_i,
    input  wire logic       hw_fault_i,
    output logic            gate_enable_o,
    output logic            inhibit_status_output_o,
    output logic            locked_o,
    output logic [9:0]      fault_code_o,
    output tic_pkg::tic_flt_s warn_o
);

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    tic_pkg::tic_in_s raw_in;
    tic_pkg::tic_in_s syn;

    assign raw_in.hw_fault = hw_fault_i;
    assign raw_in.travel   = travel_i;
    assign raw_in.chan_b   = inhibit_channel_b_i;
    assign raw_in.chan_a   = inhibit_channel_a_i;

    tic_sync #(
        .W (4)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .d_i       (raw_in),
        .q_o       (syn)
    );

    // -----------------------------------------------------------------
    // Channel decode
    // -----------------------------------------------------------------
    wire both_on  = syn.chan_a & syn.chan_b;
    wire both_off = ~syn.chan_a & ~syn.chan_b;
    wire mismatch = syn.chan_a ^ syn.chan_b;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    tic_pkg::tic_state_e state_q;
    tic_pkg::tic_state_e state_d;
    tic_pkg::tic_flt_s   flt_q;
    tic_pkg::tic_flt_s   flt_d;
    logic                lock_q;
    logic                lock_d;
    logic                gate_q;
    logic                status_q;
    logic [9:0]          code_q;
    logic [9:0]          code_d;
    logic                after_trv_q;
    logic                was_on_q;

    // -----------------------------------------------------------------
    // Interval timers
    // -----------------------------------------------------------------
    logic skew_done;
    logic lock_done;
    logic remain_done;
    logic miss_done;
    logic notrv_done;
    logic intr_done;

    // Second stage only runs once the skew warning stands
    wire run_lock   = mismatch & flt_q.skew;
    wire run_remain = syn.travel & both_off & ~was_on_q;
    wire run_miss   = ~syn.travel & both_on & after_trv_q;
    wire run_notrv  = ~syn.travel & both_on & ~after_trv_q;
    wire run_intr   = syn.travel & ~both_on & was_on_q;

    tic_timer #(
        .LIMIT (SKEW_CYC)
    ) u_t_skew (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (mismatch),
        .done_o    (skew_done)
    );

    tic_timer #(
        .LIMIT (LOCK_CYC)
    ) u_t_lock (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (run_lock),
        .done_o    (lock_done)
    );

    tic_timer #(
        .LIMIT (SEQ_CYC)
    ) u_t_remain (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (run_remain),
        .done_o    (remain_done)
    );

    tic_timer #(
        .LIMIT (SEQ_CYC)
    ) u_t_miss (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (run_miss),
        .done_o    (miss_done)
    );

    tic_timer #(
        .LIMIT (SEQ_CYC)
    ) u_t_notrv (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (run_notrv),
        .done_o    (notrv_done)
    );

    tic_timer #(
        .LIMIT (INTR_CYC)
    ) u_t_intr (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (run_intr),
        .done_o    (intr_done)
    );

    // -----------------------------------------------------------------
    // Travel sequence tracking
    // -----------------------------------------------------------------
    // after_trv_q armed by travel, disarmed when the inhibit is applied again; was_on_q clears when travel ends
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            after_trv_q <= 1'b0;
            was_on_q    <= 1'b0;
        end else if (ce_i) begin
            after_trv_q <= syn.travel | (after_trv_q & ~both_off);
            was_on_q    <= syn.travel & (both_on | was_on_q);
        end
    end

    // -----------------------------------------------------------------
    // Warning flags: sticky, only a reset clears them
    // -----------------------------------------------------------------
    assign flt_d.skew   = flt_q.skew   | skew_done;
    assign flt_d.intr   = flt_q.intr   | intr_done;
    assign flt_d.miss   = flt_q.miss   | miss_done;
    assign flt_d.remain = flt_q.remain | remain_done;
    assign flt_d.notrv  = flt_q.notrv  | notrv_done;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || por_i) begin
            flt_q <= tic_pkg::FLT_RST;
        end else if (ce_i) begin
            flt_q <= flt_d;
        end
    end

    // -----------------------------------------------------------------
    // Locked fault: survives rst_i, cleared only at line power-up
    // -----------------------------------------------------------------
    // Worst case skew plus lock stage stays under the 1600 ms bound
    assign lock_d = lock_q | lock_done | syn.hw_fault;

    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            lock_q <= 1'b0;
        end else if (ce_i) begin
            lock_q <= lock_d;
        end
    end

    // -----------------------------------------------------------------
    // Power-stage state
    // -----------------------------------------------------------------
    // Lock overrides everything; a single low channel drops the stage
    always_comb begin
        state_d = state_q;
        case (state_q)
            tic_pkg::ST_INHIBIT: begin
                if (both_on) begin
                    state_d = tic_pkg::ST_ENABLED;
                end else if (mismatch) begin
                    state_d = tic_pkg::ST_SKEW;
                end
            end
            tic_pkg::ST_ENABLED: begin
                if (mismatch) begin
                    state_d = tic_pkg::ST_SKEW;
                end else if (both_off) begin
                    state_d = tic_pkg::ST_INHIBIT;
                end
            end
            tic_pkg::ST_SKEW: begin
                if (both_on) begin
                    state_d = tic_pkg::ST_ENABLED;
                end else if (both_off) begin
                    state_d = tic_pkg::ST_INHIBIT;
                end
            end
            tic_pkg::ST_LOCKED: begin
                state_d = tic_pkg::ST_LOCKED;
            end
            default: begin
                state_d = tic_pkg::ST_INHIBIT;
            end
        endcase
        if (lock_d) begin
            state_d = tic_pkg::ST_LOCKED;
        end
    end

    // Locked state re-enters after rst_i since lock_q is kept
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= tic_pkg::ST_INHIBIT;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // No brake drive exists here: with gates off the motor coasts
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gate_q   <= 1'b0;
            status_q <= 1'b1;
        end else if (ce_i) begin
            gate_q   <= (state_d == tic_pkg::ST_ENABLED);
            status_q <= (state_d != tic_pkg::ST_ENABLED);
        end
    end

    // Highest-severity fault wins the code output
    always_comb begin
        if (lock_d) begin
            code_d = tic_pkg::FC_LOCK;
        end else if (flt_d.skew) begin
            code_d = tic_pkg::FC_SKEW;
        end else if (flt_d.intr) begin
            code_d = tic_pkg::FC_INTR;
        end else if (flt_d.miss) begin
            code_d = tic_pkg::FC_MISS;
        end else if (flt_d.remain) begin
            code_d = tic_pkg::FC_REMAIN;
        end else if (flt_d.notrv) begin
            code_d = tic_pkg::FC_NOTRV;
        end else begin
            code_d = tic_pkg::FC_NONE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            code_q <= tic_pkg::FC_NONE;
        end else if (ce_i) begin
            code_q <= code_d;
        end
    end

    assign gate_enable_o           = gate_q;
    assign inhibit_status_output_o = status_q;
    assign locked_o                = lock_q;
    assign fault_code_o            = code_q;
    assign warn_o                  = flt_q;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    chk_gate_both_on: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        (ce_i && !both_on) |=> !gate_enable_o)
        else $error("gate enabled without both channels");

    chk_gate_inhibit: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        (ce_i && both_off) |=> (!gate_enable_o && inhibit_status_output_o))
        else $error("inhibit not applied on both channels low");

    chk_single_drop: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        (gate_enable_o && ce_i && mismatch) |=> !gate_enable_o)
        else $error("single channel drop left stage on");

    chk_hw_lock: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        (ce_i && syn.hw_fault) |=> (locked_o && fault_code_o == tic_pkg::FC_LOCK))
        else $error("internal fault did not lock");

    chk_lock_sticky: assert property (@(posedge sys_clk_i)
        disable iff (por_i)
        locked_o |=> locked_o)
        else $error("locked fault cleared without power-up");

    chk_lock_cause: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        $rose(locked_o) |-> ($past(flt_q.skew) || $past(syn.hw_fault)))
        else $error("lock without prior skew warning");

    chk_skew_cause: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        $rose(flt_q.skew) |-> $past(mismatch, 2))
        else $error("skew warning without mismatch");

    chk_intr_cause: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        $rose(flt_q.intr) |-> $past(run_intr, 2))
        else $error("interruption fault without cause");

    chk_status_tie: assert property (@(posedge sys_clk_i)
        disable iff (rst_i || por_i)
        inhibit_status_output_o == !gate_enable_o)
        else $error("status output disagrees with stage");

    cov_enable: cover property (@(posedge sys_clk_i) $rose(gate_enable_o));
    cov_lock:   cover property (@(posedge sys_clk_i) $rose(locked_o));
    cov_notrv:  cover property (@(posedge sys_clk_i) $rose(flt_q.notrv));
    cov_intr:   cover property (@(posedge sys_clk_i) $rose(flt_q.intr));

endmodule : tic_monitor
`default_nettype wire

// ===== hdl/tic_pkg.sv
// Contract
// - Power-stage enables only while both inhibit channels are high together.
// - Both channels low enters torque inhibit, all gate enables blocked.
// - Channels compared continuously; mismatch or internal fault switches drive off.
// - Either channel going low alone disables the output stage at once.
// - Skew up to 120 ms tolerated; longer raises warning fault 533.
// - Mismatch persisting after 533 locks with fault 960, 190..1480 ms later.
// - Differing contacts reach safe switch-off within 1600 ms of mismatch.
// - Diagnostic faults lock; only line power-up clears, never reset.
// - Both channels low 2,5 s into travel raises fault 348.
// - Both channels high 2,5 s after travel ends raises fault 532.
// - Both high at standstill, no travel in 2,5 s, raises 349.
// - Channels dropped during travel raise fault 531 after 200 ms.
// - Inhibit state shown on non-safety status output.
// - No active braking during inhibit; drive coasts.
package tic_pkg;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
    localparam int unsigned SKEW_MS     = 120;
    localparam int unsigned LOCK_MIN_MS = 190;
    localparam int unsigned LOCK_TYP_MS = 630;
    localparam int unsigned LOCK_MAX_MS = 1480;
    localparam int unsigned OFF_MAX_MS  = 1600;
    localparam int unsigned SEQ_MS      = 2500;
    localparam int unsigned INTR_MS     = 200;
    localparam int unsigned SKEW_CYC    = SKEW_MS * CYC_PER_MS;
    localparam int unsigned LOCK_CYC    = LOCK_TYP_MS * CYC_PER_MS;
    localparam int unsigned SEQ_CYC     = SEQ_MS * CYC_PER_MS;
    localparam int unsigned INTR_CYC    = INTR_MS * CYC_PER_MS;
    localparam int unsigned CNT_W       = 27;

    // -----------------------------------------------------------------
    // Fault codes
    // -----------------------------------------------------------------
    localparam logic [9:0] FC_NONE   = 10'h000;
    localparam logic [9:0] FC_REMAIN = 10'h15c;  // 348
    localparam logic [9:0] FC_NOTRV  = 10'h15d;  // 349
    localparam logic [9:0] FC_INTR   = 10'h213;  // 531
    localparam logic [9:0] FC_MISS   = 10'h214;  // 532
    localparam logic [9:0] FC_SKEW   = 10'h215;  // 533
    localparam logic [9:0] FC_LOCK   = 10'h3c0;  // 960

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic hw_fault;
        logic travel;
        logic chan_b;
        logic chan_a;
    } tic_in_s;

    typedef struct packed {
        logic skew;
        logic intr;
        logic miss;
        logic remain;
        logic notrv;
    } tic_flt_s;

    localparam tic_flt_s FLT_RST = '0;

    typedef enum logic [1:0] {
        ST_INHIBIT = 2'b00,
        ST_ENABLED = 2'b01,
        ST_SKEW    = 2'b11,
        ST_LOCKED  = 2'b10
    } tic_state_e;

endpackage : tic_pkg

// ===== hdl/tic_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tic_sync #(
    parameter int unsigned W = 4
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // -----------------------------------------------------------------
    // Two stages per bit; first stage feeds only the second
    // -----------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else if (ce_i) begin
                meta_q[i] <= d_i[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign q_o = sync_q;
endmodule : tic_sync
`default_nettype wire

// ===== hdl/tic_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tic_timer #(
    parameter int unsigned LIMIT = 2
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic run_i,
    output logic      done_o
);
    localparam logic [tic_pkg::CNT_W-1:0] LAST = tic_pkg::CNT_W'(LIMIT - 1);

    logic [tic_pkg::CNT_W-1:0] cnt_q;
    logic                      done_q;
    wire                       at_last = (cnt_q == LAST);

    // Counts while run holds; any drop restarts the interval
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || (ce_i && !run_i)) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ce_i) begin
            if (!at_last) begin
                cnt_q <= cnt_q + 1'b1;
            end
            done_q <= at_last;
        end
    end

    assign done_o = done_q;
endmodule : tic_timer
`default_nettype wire
